/* rtl/rn_regulator_ctrl.sv */
// control registers and enable sequencing of the ninth regulator
`timescale 1ns/10ps
`default_nettype none

module rn_regulator_ctrl
   import rn_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // register port
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   // power sequencer timeslots
   input wire logic slotPulse,
   input wire logic [2:0] slotNum,
   input wire logic sleepSeq,
   // hardware enable and control inputs
   input wire logic hwEnable1,
   input wire logic hwEnable2,
   input wire logic hwControl1,
   input wire logic hwControl2,
   // undervoltage detector
   input wire logic uvFault,
   // regulator controls
   output logic regulatorOn,
   output logic lowPowerMode,
   output logic [4:0] voltageCode,
   output logic [11:0] voltageMv,
   output logic outputDischarge,
   output logic passSwitchMode,
   output logic deviceResetReq,
   output logic irq
);

   // =====================================================
   // registers
   logic [15:0] ctrl_r;
   logic [15:0] onCtrl_r;
   logic [15:0] sleepCtrl_r;
   logic [0:0] irqStat_r;
   logic [0:0] irqMask_r;
   logic [15:0] rdata_r;
   logic uvPrev_r;
   rn_state_e state_r;
   rn_state_e state_nxt;
   logic regOn_r;
   logic lowPower_r;
   logic [4:0] vcode_r;
   logic [11:0] vmv_r;
   logic discharge_r;
   logic swi_r;
   logic devReset_r;

   // =====================================================
   // field views
   wire [1:0] undervoltageAction = ctrl_r[RN_ERR_ACT_LSB +: 2];
   wire [1:0] hwControlSource = ctrl_r[RN_HWC_SRC_LSB +: 2];
   wire hwControlVoltageChoice = ctrl_r[RN_HWC_VSEL_BIT];
   wire [1:0] hwControlOpMode = ctrl_r[RN_HWC_MODE_LSB +: 2];
   wire outputFloatWhenOff = ctrl_r[RN_FLT_BIT];
   wire passSwitchModeBit = ctrl_r[RN_SWI_BIT];
   wire [2:0] startupSlot = onCtrl_r[RN_SLOT_LSB +: 3];
   wire onOpMode = onCtrl_r[RN_MODE_BIT];
   wire [4:0] onVoltageCode = onCtrl_r[RN_VSEL_LSB +: 5];
   wire [2:0] sleepSlot = sleepCtrl_r[RN_SLOT_LSB +: 3];
   wire sleepOpMode = sleepCtrl_r[RN_MODE_BIT];
   wire [4:0] sleepVoltageCode = sleepCtrl_r[RN_VSEL_LSB +: 5];

   // =====================================================
   // register decode
   wire selCtrl = (regAddr == RN_ADDR_CTRL);
   wire selOn = (regAddr == RN_ADDR_ON);
   wire selSleep = (regAddr == RN_ADDR_SLEEP);
   wire selStat = (regAddr == RN_ADDR_IRQ_STAT);
   wire selMask = (regAddr == RN_ADDR_IRQ_MASK);
   wire [15:0] rdMux = selCtrl ? ctrl_r :
                       selOn ? onCtrl_r :
                       selSleep ? sleepCtrl_r :
                       selStat ? {15'h0000, irqStat_r} :
                       selMask ? {15'h0000, irqMask_r} : 16'h0000;

   // =====================================================
   // undervoltage events
   wire uvEvent = uvFault & ~uvPrev_r;
   wire uvShutdown = uvEvent & (undervoltageAction == RN_ACT_SHUTDOWN);
   wire uvReset = uvEvent & (undervoltageAction == RN_ACT_RESET);
   // status clear by writing one, a new event wins
   wire [0:0] statClr = (regWr & selStat) ? regWdata[0:0] : 1'h0;
   wire [0:0] stat_nxt = (irqStat_r & ~statClr) | uvEvent;

   // =====================================================
   // hardware enable and hardware control selection
   wire hwEnMode = (startupSlot == RN_SLOT_HWEN1) | (startupSlot == RN_SLOT_HWEN2);
   wire hwEnLevel = (startupSlot == RN_SLOT_HWEN1) ? hwEnable1 : hwEnable2;
   wire hwcActive = (hwControlSource[0] & hwControl1) | (hwControlSource[1] & hwControl2);

   // =====================================================
   // sequencer slot matching
   wire startSlotValid = (startupSlot != RN_SLOT_NONE) & (startupSlot <= RN_SLOT_LAST);
   wire startMatch = slotPulse & ~sleepSeq & startSlotValid & (slotNum == startupSlot);
   wire sleepCodeDisable = (sleepSlot != RN_SLOT_NONE) & (sleepSlot <= RN_SLOT_LAST);
   // codes 1..5 count down from timeslot 5
   wire [2:0] sleepSlotNum = (sleepSlot == RN_SLOT_NONE) ? RN_TS5 :
                             sleepCodeDisable ? 3'(RN_SLOT_SIX - sleepSlot) :
                             (sleepSlot == RN_SLOT_HWEN1) ? RN_TS3 : RN_TS1;
   wire sleepMatch = slotPulse & sleepSeq & (slotNum == sleepSlotNum);
   wire wakeMatch = slotPulse & ~sleepSeq & (slotNum == sleepSlotNum);
   wire sleepDisables = sleepCodeDisable & ~hwEnMode;

   // =====================================================
   // state transitions, fault shutdown has priority
   always_comb begin
      state_nxt = state_r;
      if (uvShutdown) begin
         state_nxt = ST_OFF;
      end else if (hwEnMode) begin
         if (!hwEnLevel) begin
            state_nxt = ST_OFF;
         end else if (state_r == ST_OFF) begin
            state_nxt = ST_ON;
         end else if (state_r == ST_ON && sleepMatch) begin
            state_nxt = ST_SLEEP;
         end else if (state_r == ST_SLEEP && wakeMatch) begin
            state_nxt = ST_ON;
         end
      end else begin
         unique case (state_r)
            ST_OFF: begin
               if (startMatch) begin
                  state_nxt = ST_ON;
               end
            end
            ST_ON: begin
               if (sleepMatch) begin
                  state_nxt = sleepDisables ? ST_OFF : ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (startMatch) begin
                  state_nxt = ST_ON;
               end
            end
            default: begin
               state_nxt = ST_OFF;
            end
         endcase
      end
   end

   // =====================================================
   // effective regulator settings
   wire hwcApplies = hwcActive & (state_r != ST_OFF);
   wire hwcOff = hwcApplies & (hwControlOpMode == RN_HWM_OFF);
   wire hwcLowPower = (hwControlOpMode == RN_HWM_ON_MODE) ? onOpMode : 1'b1;
   wire [4:0] hwcVolt = hwControlVoltageChoice ? sleepVoltageCode : onVoltageCode;
   wire enEff = (state_r != ST_OFF) & ~hwcOff;
   wire lpEff = hwcApplies ? hwcLowPower :
                (state_r == ST_SLEEP) ? sleepOpMode : onOpMode;
   wire [4:0] vEff = hwcApplies ? hwcVolt :
                     (state_r == ST_SLEEP) ? sleepVoltageCode : onVoltageCode;
   // two straight segments of the voltage scale
   wire [11:0] vLo = RN_V_BASE_LO + 12'(vEff) * RN_V_STEP_LO;
   wire [11:0] vHi = RN_V_BASE_HI + 12'(vEff - RN_V_KNEE) * RN_V_STEP_HI;
   wire [11:0] mvEff = (vEff < RN_V_KNEE) ? vLo : vHi;

   // =====================================================
   // software register writes, reserved bits are dropped
   // a write to an unmapped address selects nothing and is lost
   wire wrCtrl = regWr & selCtrl;
   wire wrOn = regWr & selOn;
   wire wrSleep = regWr & selSleep;
   wire wrMask = regWr & selMask;

   // control register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= RN_CTRL_RST;
      end else if (wrCtrl) begin
         ctrl_r <= regWdata & RN_CTRL_BITS;
      end
   end

   // on control register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         onCtrl_r <= RN_ON_RST;
      end else if (wrOn) begin
         onCtrl_r <= regWdata & RN_ON_BITS;
      end
   end

   // sleep control register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sleepCtrl_r <= RN_SLEEP_RST;
      end else if (wrSleep) begin
         sleepCtrl_r <= regWdata & RN_SLEEP_BITS;
      end
   end

   // interrupt mask register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irqMask_r <= RN_IRQ_RST;
      end else if (wrMask) begin
         irqMask_r <= regWdata[0:0];
      end
   end

   // read data for exactly one cycle after the strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= regRd ? rdMux : 16'h0000;
      end
   end

   // fault edge and sticky status
   // the edge flop resets to the idle level, so no false event follows reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         uvPrev_r <= 1'h0;
         irqStat_r <= RN_IRQ_RST;
      end else begin
         uvPrev_r <= uvFault;
         irqStat_r <= stat_nxt;
      end
   end

   // sequencing state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // device reset request, one cycle per fault event under the reset action
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         devReset_r <= 1'h0;
      end else begin
         devReset_r <= uvReset;
      end
   end

   // enable, discharge and switch mode
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         regOn_r <= 1'h0;
         discharge_r <= 1'h0;
         swi_r <= 1'h0;
      end else begin
         regOn_r <= enEff;
         discharge_r <= ~enEff & ~outputFloatWhenOff;
         swi_r <= passSwitchModeBit;
      end
   end

   // operating mode and voltage, code and millivolts move together
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lowPower_r <= 1'h0;
         vcode_r <= 5'h00;
         vmv_r <= 12'h000;
      end else begin
         lowPower_r <= lpEff;
         vcode_r <= vEff;
         vmv_r <= mvEff;
      end
   end

   // =====================================================
   // outputs
   assign regRdata = rdata_r;
   assign regulatorOn = regOn_r;
   assign lowPowerMode = lowPower_r;
   assign voltageCode = vcode_r;
   assign voltageMv = vmv_r;
   assign outputDischarge = discharge_r;
   assign passSwitchMode = swi_r;
   assign deviceResetReq = devReset_r;
   assign irq = |(irqStat_r & irqMask_r);
endmodule
`default_nettype wire

/* shared/rn_pkg.sv */
// constants and types for the ninth regulator control block
`default_nettype none
package rn_pkg;
   // =====================================================
   // register addresses
   localparam logic [15:0] RN_ADDR_CTRL = 16'h4080;
   localparam logic [15:0] RN_ADDR_ON = 16'h4081;
   localparam logic [15:0] RN_ADDR_SLEEP = 16'h4082;
   localparam logic [15:0] RN_ADDR_IRQ_STAT = 16'h4088;
   localparam logic [15:0] RN_ADDR_IRQ_MASK = 16'h4089;

   // =====================================================
   // implemented bits and values after reset
   localparam logic [15:0] RN_CTRL_BITS = 16'hdfc0;
   localparam logic [15:0] RN_ON_BITS = 16'he11f;
   localparam logic [15:0] RN_SLEEP_BITS = 16'he11f;
   localparam logic [15:0] RN_CTRL_RST = 16'h0200;
   localparam logic [15:0] RN_ON_RST = 16'h0000;
   localparam logic [15:0] RN_SLEEP_RST = 16'h0100;
   localparam logic [0:0] RN_IRQ_RST = 1'h0;

   // =====================================================
   // field positions
   localparam int RN_ERR_ACT_LSB = 14;
   localparam int RN_HWC_SRC_LSB = 11;
   localparam int RN_HWC_VSEL_BIT = 10;
   localparam int RN_HWC_MODE_LSB = 8;
   localparam int RN_FLT_BIT = 7;
   localparam int RN_SWI_BIT = 6;
   localparam int RN_SLOT_LSB = 13;
   localparam int RN_MODE_BIT = 8;
   localparam int RN_VSEL_LSB = 0;

   // =====================================================
   // field codes
   localparam logic [1:0] RN_ACT_IGNORE = 2'h0;
   localparam logic [1:0] RN_ACT_SHUTDOWN = 2'h1;
   localparam logic [1:0] RN_ACT_RESET = 2'h2;
   localparam logic [1:0] RN_HWM_OFF = 2'h1;
   localparam logic [1:0] RN_HWM_ON_MODE = 2'h3;
   localparam logic [2:0] RN_SLOT_NONE = 3'h0;
   localparam logic [2:0] RN_SLOT_LAST = 3'h5;
   localparam logic [2:0] RN_SLOT_HWEN1 = 3'h6;
   localparam logic [2:0] RN_SLOT_HWEN2 = 3'h7;
   localparam logic [2:0] RN_SLOT_SIX = 3'h6;
   localparam logic [2:0] RN_TS1 = 3'h1;
   localparam logic [2:0] RN_TS3 = 3'h3;
   localparam logic [2:0] RN_TS5 = 3'h5;

   // =====================================================
   // voltage code to millivolts
   localparam logic [4:0] RN_V_KNEE = 5'h0d;
   localparam logic [11:0] RN_V_BASE_LO = 12'd1000;
   localparam logic [11:0] RN_V_STEP_LO = 12'd50;
   localparam logic [11:0] RN_V_BASE_HI = 12'd1700;
   localparam logic [11:0] RN_V_STEP_HI = 12'd100;

   // regulator sequencing state
   typedef enum logic [1:0] {ST_OFF, ST_ON, ST_SLEEP} rn_state_e;
endpackage
`default_nettype wire

/* tb/rn_regulator_ctrl_assertions.sv */
// port checks for the ninth regulator control block
`timescale 1ns/10ps
`default_nettype none
module rn_regulator_ctrl_assertions
   import rn_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // register port
   input wire logic [15:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdata,
   // fault and regulator controls
   input wire logic uvFault,
   input wire logic regulatorOn,
   input wire logic outputDischarge,
   input wire logic [4:0] voltageCode,
   input wire logic [11:0] voltageMv,
   input wire logic deviceResetReq,
   input wire logic irq
);
   // ==========
   // expected millivolts of the applied code
   wire logic [11:0] mvExp;
   assign mvExp = voltageCode < RN_V_KNEE ? RN_V_BASE_LO + RN_V_STEP_LO * 12'(voltageCode)
      : RN_V_BASE_HI + RN_V_STEP_HI * 12'(voltageCode - RN_V_KNEE);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ==========
   // bus, voltage, fault and interrupt relations
   AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 16'h0000) else $error("rdata");
   AST_RD_HOLE: assert property ($past(regRd) && $past(regAddr) > RN_ADDR_SLEEP &&
      $past(regAddr) < RN_ADDR_IRQ_STAT |-> regRdata == 16'h0000) else $error("hole");
   AST_RSVD_ON: assert property ($past(regRd) && $past(regAddr) == RN_ADDR_ON |->
      (regRdata & ~RN_ON_BITS) == 16'h0000) else $error("on bits");
   AST_VOLT: assert property ($past(rstn) |-> voltageMv == mvExp) else $error("mv");
   AST_DISCH: assert property (regulatorOn |-> !outputDischarge) else $error("disch");
   AST_DRST_ONE: assert property (deviceResetReq |=> !deviceResetReq) else $error("pulse");
   AST_DRST_WHY: assert property (deviceResetReq |-> $past(uvFault) && !$past(uvFault, 2))
      else $error("cause");
   AST_IRQ_UP: assert property ($rose(irq) |-> $past(regWr) || ($past(uvFault) &&
      !$past(uvFault, 2))) else $error("irq up");
   AST_IRQ_DN: assert property ($fell(irq) |-> $past(regWr)) else $error("irq down");
endmodule
`default_nettype wire

/* tb/rn_regulator_ctrl_tb.sv */
// random and directed bench for the ninth regulator control block
`timescale 1ns/10ps
`default_nettype none
module rn_regulator_ctrl_tb
   import rn_pkg::*;
;
   // design signals and bench state
   logic mclk, rstn, regWr, regRd, slotPulse, sleepSeq, hwEnable1, hwEnable2, hwControl1, hwControl2, uvFault;
   logic regulatorOn, lowPowerMode, outputDischarge, passSwitchMode, deviceResetReq, irq;
   logic [15:0] regAddr, regWdata, regRdata, d, a;
   logic [2:0] slotNum;
   logic [4:0] voltageCode, c, s;
   logic [11:0] voltageMv;
   logic [4:0] ks [3] = '{5'h0c, 5'h0d, 5'h1f};
   integer seed = 53, fails = 0, comparisons = 0, cyc = 0, pulses = 0;
   rn_regulator_ctrl uut (.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .slotPulse, .slotNum,
      .sleepSeq, .hwEnable1, .hwEnable2, .hwControl1, .hwControl2, .uvFault, .regulatorOn, .lowPowerMode,
      .voltageCode, .voltageMv, .outputDischarge, .passSwitchMode, .deviceResetReq, .irq);
   // clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // ==========
   // helpers
   function automatic logic [11:0] mv(logic [4:0] k);
      return k < 5'h0d ? 12'd1000 + 12'd50 * k : 12'd1700 + 12'd100 * (k - 5'h0d);
   endfunction
   task automatic complete_run;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [15:0] ad, logic [15:0] v);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= ad;
      regWdata <= v;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(logic [15:0] ad, logic [15:0] v);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= ad;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      chk("regRdata", regRdata, v);
   endtask
   task automatic settle;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic slot(logic [2:0] n, logic q);
      @(posedge mclk);
      slotPulse <= 1'b1;
      slotNum <= n;
      sleepSeq <= q;
      @(posedge mclk);
      slotPulse <= 1'b0;
      settle;
   endtask
   task automatic hw(logic x, logic y);
      @(posedge mclk);
      hwControl1 <= x;
      hwControl2 <= y;
      settle;
   endtask
   task automatic fault;
      @(posedge mclk);
      uvFault <= 1'b1;
      repeat (4) @(posedge mclk);
      uvFault <= 1'b0;
      @(negedge mclk);
   endtask
   task automatic outs(logic on, logic lp, logic dis, logic [4:0] k);
      chk("outputs", {8'h0, regulatorOn, lowPowerMode, outputDischarge, voltageCode}, {8'h0, on, lp, dis, k});
      chk("voltageMv", {4'h0, voltageMv}, {4'h0, mv(k)});
   endtask
   task automatic en(logic on, logic dis);
      chk("enable", {14'h0, regulatorOn, outputDischarge}, {14'h0, on, dis});
   endtask
   // hang guard and reset request count
   always @(posedge mclk) begin
      cyc++;
      if (deviceResetReq === 1'b1)
         pulses++;
      if (cyc == 5000) begin
         fails++;
         complete_run;
      end
   end
   // ==========
   // main sequence
   initial begin
      {rstn, regWr, regRd, slotPulse, sleepSeq, hwEnable1, hwEnable2, hwControl1, hwControl2, uvFault} = '0;
      {regAddr, regWdata, slotNum} = '0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      rd(RN_ADDR_CTRL, RN_CTRL_RST);
      rd(RN_ADDR_ON, RN_ON_RST);
      rd(RN_ADDR_SLEEP, RN_SLEEP_RST);
      rd(RN_ADDR_IRQ_STAT, 16'h0000);
      for (int i = 0; i < 9; i++) begin
         d = 16'($random(seed));
         a = RN_ADDR_CTRL + 16'(i % 3);
         wr(a, d);
         rd(a, d & (i % 3 == 0 ? RN_CTRL_BITS : RN_ON_BITS));
      end
      wr(16'h4083, d);
      rd(16'h4083, 16'h0000);
      // start-up, voltage steps, sleep entry
      c = 5'($random(seed));
      wr(RN_ADDR_CTRL, 16'h0000);
      wr(RN_ADDR_ON, {3'h2, 8'h00, c});
      slot(3'h1, 1'b0);
      en(1'b0, 1'b1);
      slot(3'h2, 1'b0);
      outs(1'b1, 1'b0, 1'b0, c);
      foreach (ks[j]) begin
         wr(RN_ADDR_ON, {3'h2, 4'h0, 1'b1, 3'h0, ks[j]});
         settle;
         outs(1'b1, 1'b1, 1'b0, ks[j]);
      end
      s = 5'($random(seed));
      wr(RN_ADDR_SLEEP, {8'h00, 3'h0, s});
      slot(3'h5, 1'b1);
      outs(1'b1, 1'b0, 1'b0, s);
      slot(3'h2, 1'b0);
      outs(1'b1, 1'b1, 1'b0, 5'h1f);
      wr(RN_ADDR_SLEEP, {3'h6, 4'h0, 1'b1, 3'h0, s});
      slot(3'h3, 1'b1);
      outs(1'b1, 1'b1, 1'b0, s);
      slot(3'h2, 1'b0);
      wr(RN_ADDR_SLEEP, {3'h3, 8'h00, s});
      slot(3'h3, 1'b1);
      en(1'b0, 1'b1);
      wr(RN_ADDR_CTRL, 16'h00c0);
      settle;
      en(1'b0, 1'b0);
      chk("passSwitchMode", {15'h0, passSwitchMode}, 16'h0001);
      // hardware control sources, voltage and mode
      wr(RN_ADDR_CTRL, 16'h0f00);
      slot(3'h2, 1'b0);
      hw(1'b1, 1'b0);
      outs(1'b1, 1'b1, 1'b0, s);
      wr(RN_ADDR_CTRL, 16'h0d00);
      settle;
      en(1'b0, 1'b1);
      chk("passSwitchMode", {15'h0, passSwitchMode}, 16'h0000);
      wr(RN_ADDR_CTRL, 16'h1100);
      settle;
      outs(1'b1, 1'b1, 1'b0, 5'h1f);
      hw(1'b0, 1'b1);
      en(1'b0, 1'b1);
      wr(RN_ADDR_ON, 16'h401f);
      wr(RN_ADDR_CTRL, 16'h1800);
      settle;
      outs(1'b1, 1'b1, 1'b0, 5'h1f);
      hw(1'b0, 1'b0);
      outs(1'b1, 1'b0, 1'b0, 5'h1f);
      // undervoltage actions and interrupt
      wr(RN_ADDR_IRQ_MASK, 16'h0001);
      wr(RN_ADDR_CTRL, 16'h8000);
      fault;
      chk("irq", {15'h0, irq}, 16'h0001);
      chk("pulses", 16'(pulses), 16'h0001);
      wr(RN_ADDR_IRQ_STAT, 16'h0001);
      rd(RN_ADDR_IRQ_STAT, 16'h0000);
      wr(RN_ADDR_CTRL, 16'h4000);
      fault;
      en(1'b0, 1'b1);
      wr(RN_ADDR_IRQ_MASK, 16'h0000);
      rd(RN_ADDR_IRQ_STAT, 16'h0001);
      chk("irq", {15'h0, irq}, 16'h0000);
      wr(RN_ADDR_IRQ_STAT, 16'h0001);
      wr(RN_ADDR_CTRL, 16'h0000);
      slot(3'h2, 1'b0);
      fault;
      outs(1'b1, 1'b0, 1'b0, 5'h1f);
      rd(RN_ADDR_IRQ_STAT, 16'h0001);
      chk("pulses", 16'(pulses), 16'h0001);
      // hardware enable and its sleep entry
      wr(RN_ADDR_ON, 16'hc000);
      settle;
      en(1'b0, 1'b1);
      @(posedge mclk);
      hwEnable1 <= 1'b1;
      settle;
      en(1'b1, 1'b0);
      wr(RN_ADDR_SLEEP, {3'h3, 4'h0, 1'b1, 3'h0, s});
      slot(3'h3, 1'b1);
      outs(1'b1, 1'b1, 1'b0, s);
      // second hardware enable, reserved action, last sleep code, hardware mode 10
      wr(RN_ADDR_ON, 16'he000);
      settle;
      en(1'b0, 1'b1);
      @(posedge mclk);
      hwEnable2 <= 1'b1;
      settle;
      en(1'b1, 1'b0);
      wr(RN_ADDR_CTRL, 16'hc000);
      fault;
      chk("pulses", 16'(pulses), 16'h0001);
      wr(RN_ADDR_SLEEP, {3'h7, 4'h0, 1'b1, 3'h0, s});
      slot(3'h1, 1'b1);
      outs(1'b1, 1'b1, 1'b0, s);
      wr(RN_ADDR_CTRL, 16'h0a00);
      hw(1'b1, 1'b0);
      outs(1'b1, 1'b1, 1'b0, 5'h00);
      complete_run;
   end
endmodule
bind rn_regulator_ctrl rn_regulator_ctrl_assertions checks (.mclk, .rstn, .regAddr, .regWr, .regRd, .regRdata,
   .uvFault, .regulatorOn, .outputDischarge, .voltageCode, .voltageMv, .deviceResetReq, .irq);
`default_nettype wire
